// ### aorg_pkg.sv
package aorg_pkg;
    // ------------------------------------------------------------
    // Timing, data width and reset values
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50000000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int DATA_W = 16;
    localparam logic signed [15:0] OUT_RESET = 16'sh0000;
    localparam logic [15:0] TIMER_RESET = 16'h0000;
endpackage

// ### aorg_tick_if.sv
`timescale 1ns/1ps
interface aorg_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// ### aorg_timebase.sv
`timescale 1ns/1ps
module aorg_timebase
    import aorg_pkg::*;
#(
    parameter int PERIOD = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    aorg_tick_if.src tk
);
    // ------------------------------------------------------------
    // 10 ms tick divider
    // ------------------------------------------------------------
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    // Free running divider
    always_comb begin
        if (cnt_r >= 32'(PERIOD - 1)) begin
            cnt_nxt = 32'h0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 32'h1;
            tick_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 32'h0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tk.tick = tick_r;
endmodule // aorg_timebase

// ### aorg_ramp.sv
// Notes on behaviour
// RULE1: Trigger rising edge clears the ramp timer before ramping starts.
// RULE2: Up direction loads lower limit, adds span/preset per tick, flags top.
// RULE3: Step mode 1 moves output by preset each tick in latched direction.
// RULE4: Down direction loads upper limit, subtracts span/preset, flags bottom.
// RULE5: Direction is latched at trigger; later changes are ignored.
// RULE6: Pause holds the output; release resumes until the target.
// RULE7: Upper not above lower means no ramp and error flag set.
// RULE8: Word after the output is private working storage of the generator.
// RULE9: Controller provides a dedicated 10 ms timebase timer.
// RULE10: Preset counts 10 ms units: duration or per-tick increment.
// RULE11: Limits are signed 16-bit two's complement values.
// RULE12: Mode 0 ends when timer reaches preset; output equals target.
// RULE13: Output is clamped at the target and stepping stops there.
`timescale 1ns/1ps
module aorg_ramp
    import aorg_pkg::*;
#(
    parameter int TICK_PERIOD = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic trigger,
    input wire logic dir_up,
    input wire logic step_mode_bit,
    input wire logic pause_input,
    input wire logic [15:0] ramp_preset,
    input wire logic signed [15:0] lower_limit,
    input wire logic signed [15:0] upper_limit,
    output logic signed [15:0] ramp_out,
    output logic [15:0] work_word,
    output logic [15:0] ramp_timer,
    output logic upper_reached_flag,
    output logic lower_reached_flag,
    output logic error_flag,
    output logic active
);
    // ------------------------------------------------------------
    // Input synchronisers and trigger edge
    // ------------------------------------------------------------
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic trig_d_r;
    logic trig_s;
    logic dir_s;
    logic mode_s;
    logic pause_s;
    logic trig_edge;

    // Two flip-flop synchronisers and trigger delay
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
            trig_d_r <= 1'b0;
        end else begin
            s1_r <= {pause_input, step_mode_bit, dir_up, trigger};
            s2_r <= s1_r;
            trig_d_r <= s2_r[0];
        end
    end

    // Synchronised views and trigger rising edge
    assign trig_s = s2_r[0];
    assign dir_s = s2_r[1];
    assign mode_s = s2_r[2];
    assign pause_s = s2_r[3];
    assign trig_edge = trig_s & ~trig_d_r;

    // ------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------
    // Free running 10 ms tick source
    aorg_tick_if tk ();

    aorg_timebase #(.PERIOD(TICK_PERIOD)) u_tb (
        .clk(clk),
        .resetn(resetn),
        .tk(tk)
    );

    // ------------------------------------------------------------
    // Ramp state machine
    // ------------------------------------------------------------
    typedef enum {AORG_IDLE, AORG_RUN, AORG_DONE} aorg_state_t;

    aorg_state_t st_r;
    aorg_state_t st_nxt;
    logic signed [15:0] out_r;
    logic signed [15:0] out_nxt;
    logic [15:0] step_r;
    logic [15:0] step_nxt;
    logic [15:0] tmr_r;
    logic [15:0] tmr_nxt;
    logic up_r;
    logic up_nxt;
    logic mode_r;
    logic mode_nxt;
    logic asu_r;
    logic asu_nxt;
    logic asl_r;
    logic asl_nxt;
    logic err_r;
    logic err_nxt;

    logic signed [17:0] span;
    logic signed [17:0] cand;
    logic signed [17:0] tgt;
    logic [15:0] inc;
    logic reached;

    // Span over preset, zero-safe
    function automatic logic [15:0] span_step(input logic signed [17:0] sp,
                                              input logic [15:0] pv);
        logic [17:0] q;
        q = 18'h0;
        if (pv != 16'h0) begin
            q = 18'(sp) / {2'b00, pv};
        end
        return q[15:0];
    endfunction

    // Next state, value, timer and flags
    always_comb begin
        st_nxt = st_r;
        out_nxt = out_r;
        step_nxt = step_r;
        tmr_nxt = tmr_r;
        up_nxt = up_r;
        mode_nxt = mode_r;
        asu_nxt = asu_r;
        asl_nxt = asl_r;
        err_nxt = err_r;
        // Signed span of the limits
        span = 18'(upper_limit) - 18'(lower_limit); // [RULE11]
        inc = mode_r ? ramp_preset : step_r; // [RULE10]
        tgt = up_r ? 18'(upper_limit) : 18'(lower_limit);
        cand = up_r ? 18'(out_r) + 18'({2'b00, inc})
                    : 18'(out_r) - 18'({2'b00, inc});
        reached = up_r ? (cand >= tgt) : (cand <= tgt);
        if (!mode_r && (32'(tmr_r) + 32'h1 >= 32'(ramp_preset))) begin
            reached = 1'b1; // [RULE12]
        end
        case (st_r)
            AORG_IDLE, AORG_DONE: begin
                if (trig_edge) begin
                    tmr_nxt = TIMER_RESET; // [RULE1]
                    asu_nxt = 1'b0;
                    asl_nxt = 1'b0;
                    if (span <= 18'sh0) begin
                        err_nxt = 1'b1; // [RULE7]
                        st_nxt = AORG_IDLE;
                    end else begin
                        err_nxt = 1'b0;
                        up_nxt = dir_s; // [RULE5]
                        mode_nxt = mode_s;
                        step_nxt = span_step(span, ramp_preset);
                        // Up starts low, down starts high
                        out_nxt = dir_s ? lower_limit
                                        : upper_limit; // [RULE2] [RULE4]
                        st_nxt = AORG_RUN;
                    end
                end
            end
            AORG_RUN: begin
                if (tk.tick && !pause_s) begin // [RULE6]
                    tmr_nxt = tmr_r + 16'h1;
                    if (reached) begin
                        out_nxt = tgt[15:0]; // [RULE13]
                        asu_nxt = up_r; // [RULE2]
                        asl_nxt = ~up_r; // [RULE4]
                        st_nxt = AORG_DONE;
                    end else begin
                        out_nxt = cand[15:0]; // [RULE3]
                    end
                end
            end
            default: st_nxt = AORG_IDLE;
        endcase
    end

    // Ramp state registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= AORG_IDLE;
            out_r <= OUT_RESET;
            step_r <= 16'h0;
            tmr_r <= TIMER_RESET;
            up_r <= 1'b0;
            mode_r <= 1'b0;
            asu_r <= 1'b0;
            asl_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            out_r <= out_nxt;
            step_r <= step_nxt;
            tmr_r <= tmr_nxt;
            up_r <= up_nxt;
            mode_r <= mode_nxt;
            asu_r <= asu_nxt;
            asl_r <= asl_nxt;
            err_r <= err_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic act_r;

    // Busy flag follows the next state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            act_r <= 1'b0;
        end else begin
            act_r <= (st_nxt == AORG_RUN);
        end
    end

    // Outputs straight from registers
    assign ramp_out = out_r;
    assign work_word = step_r; // [RULE8]
    assign ramp_timer = tmr_r;
    assign upper_reached_flag = asu_r;
    assign lower_reached_flag = asl_r;
    assign error_flag = err_r;
    assign active = act_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Trigger start: timer cleared, start value loaded
    timer_clear_a: assert property ( // [RULE1]
        @(posedge clk) disable iff (!resetn)
        (st_r != AORG_RUN && trig_edge) |=> tmr_r == 16'h0)
        else $error("ramp timer not cleared on trigger");

    up_load_a: assert property ( // [RULE2]
        @(posedge clk) disable iff (!resetn)
        (st_r != AORG_RUN && trig_edge && dir_s && span > 0)
        |=> out_r == $past(lower_limit))
        else $error("up ramp did not load lower limit");

    down_load_a: assert property ( // [RULE4]
        @(posedge clk) disable iff (!resetn)
        (st_r != AORG_RUN && trig_edge && !dir_s && span > 0)
        |=> out_r == $past(upper_limit))
        else $error("down ramp did not load upper limit");

    // Direction taken at the trigger and held to the end
    dir_latch_a: assert property ( // [RULE5]
        @(posedge clk) disable iff (!resetn)
        (st_r != AORG_RUN && trig_edge && span > 0)
        |=> up_r == $past(dir_s))
        else $error("direction not latched at trigger");

    dir_hold_a: assert property ( // [RULE5]
        @(posedge clk) disable iff (!resetn)
        (st_r == AORG_RUN && st_nxt == AORG_RUN) |=> $stable(up_r))
        else $error("direction changed during ramp");

    // Pause freezes value and timer
    pause_hold_a: assert property ( // [RULE6]
        @(posedge clk) disable iff (!resetn)
        (st_r == AORG_RUN && pause_s) |=> $stable(out_r))
        else $error("output moved while paused");

    pause_timer_a: assert property ( // [RULE6]
        @(posedge clk) disable iff (!resetn)
        (st_r == AORG_RUN && pause_s) |=> $stable(tmr_r))
        else $error("ramp timer moved while paused");

    // Limit check at trigger
    limit_err_a: assert property ( // [RULE7]
        @(posedge clk) disable iff (!resetn)
        (st_r != AORG_RUN && trig_edge && span <= 0)
        |=> err_r && st_r == AORG_IDLE)
        else $error("bad limits not flagged");

    err_clear_a: assert property ( // [RULE7]
        @(posedge clk) disable iff (!resetn)
        (st_r != AORG_RUN && trig_edge && span > 0)
        |=> !err_r && st_r == AORG_RUN)
        else $error("good limits did not start a ramp");

    // Preset-sized steps in step mode 1
    step_exact_a: assert property ( // [RULE3]
        @(posedge clk) disable iff (!resetn)
        (st_r == AORG_RUN && mode_r && up_r && tk.tick && !pause_s
         && !reached)
        |=> out_r == $past(out_r) + $past(ramp_preset))
        else $error("step mode increment wrong");

    step_down_a: assert property ( // [RULE3]
        @(posedge clk) disable iff (!resetn)
        (st_r == AORG_RUN && mode_r && !up_r && tk.tick && !pause_s
         && !reached)
        |=> out_r == $past(out_r) - $past(ramp_preset))
        else $error("step mode decrement wrong");

    // Timer counts unpaused ticks in 10 ms units
    timer_count_a: assert property ( // [RULE10]
        @(posedge clk) disable iff (!resetn)
        (st_r == AORG_RUN && tk.tick && !pause_s)
        |=> tmr_r == $past(tmr_r) + 16'h1)
        else $error("ramp timer did not count the tick");

    // Mode 0 ends when the timer meets the preset
    mode0_end_a: assert property ( // [RULE12]
        @(posedge clk) disable iff (!resetn)
        (st_r == AORG_RUN && !mode_r && tk.tick && !pause_s
         && tmr_r + 16'h1 == ramp_preset)
        |=> st_r == AORG_DONE && ramp_timer == $past(ramp_preset))
        else $error("mode 0 ramp did not end at preset");

    done_target_a: assert property ( // [RULE12] [RULE13]
        @(posedge clk) disable iff (!resetn)
        (st_r == AORG_RUN && st_nxt == AORG_DONE)
        |=> (out_r == (up_r ? upper_limit : lower_limit))
            && (upper_reached_flag == up_r))
        else $error("ramp end not at target");

    low_flag_a: assert property ( // [RULE4]
        @(posedge clk) disable iff (!resetn)
        (st_r == AORG_RUN && st_nxt == AORG_DONE && !up_r)
        |=> lower_reached_flag && !upper_reached_flag && !active)
        else $error("lower limit arrival not flagged");
endmodule // aorg_ramp

// ### aorg_ao_model.sv
`timescale 1ns/1ps
module aorg_ao_model
    import aorg_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic signed [15:0] ramp_out,
    output logic signed [15:0] ao_reg
);
    // Output register takes the ramp word only, never the work word
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ao_reg <= OUT_RESET;
        end else begin
            ao_reg <= ramp_out;
        end
    end
endmodule // aorg_ao_model

// ### analog_output_ramp_generator_test.sv
`timescale 1ns/1ps
module analog_output_ramp_generator_test;
    import aorg_pkg::*;
    typedef struct packed {
        logic signed [15:0] v;
        logic [3:0] f;
        logic [15:0] t;
    } aorg_note_t;
    logic clk = 0, resetn = 0, trigger = 0, dir_up = 0, step_mode_bit = 0;
    logic pause_input = 0, dl = 0, pa = 0;
    logic [15:0] ramp_preset = 16'h0001, work_word, ramp_timer, p, w;
    logic [15:0] d16, e16;
    logic signed [15:0] lower_limit = 0, upper_limit = 0, ramp_out, ao_reg;
    logic signed [15:0] hold, tgt, prv, a, b;
    logic upper_reached_flag, lower_reached_flag, error_flag, active;
    logic [3:0] cur, prev = 0;
    aorg_note_t q[$];
    aorg_note_t n;
    int fail_count = 0, checks = 0, seed = 32'hf308, r;

    // Dedicated tick period for this generator alone
    aorg_ramp #(.TICK_PERIOD(10)) i_aorg_ramp (.clk, .resetn, .trigger,
        .dir_up, .step_mode_bit, .pause_input, .ramp_preset, .lower_limit,
        .upper_limit, .ramp_out, .work_word, .ramp_timer, .upper_reached_flag,
        .lower_reached_flag, .error_flag, .active);
    aorg_ao_model i_aorg_ao_model (.clk, .resetn, .ramp_out, .ao_reg);

    initial forever #10 clk = ~clk;

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    task give_verdict;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Oldest note against each newly raised status bit
    always @(posedge clk) begin
        cur = {active, upper_reached_flag, lower_reached_flag, error_flag};
        if (resetn && (cur & ~prev) != 4'h0) begin
            if (q.size() == 0) begin
                chk(1'b0, "unexpected result");
            end else begin
                n = q.pop_front();
                chk(cur === n.f, "status flags");
                if (!n.f[0]) chk(ramp_out === n.v, "ramp value");
                if (n.t !== 16'hffff)
                    chk(ramp_timer === n.t, "timer");
            end
        end
        prev = cur;
    end

    // Step size in preset mode, clamped step excepted
    always @(posedge clk) begin
        if (pa && active && step_mode_bit && prv !== ramp_out &&
            ramp_out !== tgt) begin
            d16 = 16'(ramp_out - prv);
            e16 = dl ? ramp_preset : 16'(-ramp_preset);
            chk(d16 === e16, "step size");
        end
        prv = ramp_out;
        pa = active;
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    task run(input logic d, m, input logic [15:0] pr,
             input logic signed [15:0] lo, hi);
        @(posedge clk);
        dir_up <= d;
        step_mode_bit <= m;
        ramp_preset <= pr;
        lower_limit <= lo;
        upper_limit <= hi;
        trigger <= 1'b1;
        dl = d;
        tgt = d ? hi : lo;
        if (hi <= lo) begin
            q.push_back({16'sh0000, 4'b0001, 16'hffff});
        end else begin
            q.push_back({d ? lo : hi, 4'b1000, 16'h0000});
            q.push_back({tgt, d ? 4'b0100 : 4'b0010, m ? 16'hffff : pr});
        end
        repeat (6) @(posedge clk);
        if (hi > lo) begin
            w = 16'((int'(hi) - int'(lo)) / int'(pr));
            chk(work_word === w, "work word");
        end
    endtask

    task fin;
        int k;
        k = 0;
        trigger <= 1'b0;
        while (active !== 1'b0 && k < 6000) begin
            @(posedge clk);
            k++;
        end
        chk(k < 6000, "ramp never ended");
        repeat (4) @(posedge clk);
        $display("test done at %0t", $time);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        // Up ramp with direction flip, pause and refused retrigger
        run(1, 0, 16'h0007, -16'sd100, 16'sd200);
        repeat (20) @(posedge clk);
        dir_up <= 1'b0;
        pause_input <= 1'b1;
        repeat (6) @(posedge clk);
        hold = ramp_out;
        repeat (30) @(posedge clk);
        chk(ramp_out === hold && ao_reg === hold, "pause hold");
        trigger <= 1'b0;
        pause_input <= 1'b0;
        repeat (3) @(posedge clk);
        trigger <= 1'b1;
        hold = ramp_out;
        w = ramp_timer;
        repeat (6) @(posedge clk);
        chk(ramp_timer >= w && ramp_out >= hold, "retrigger");
        fin;
        // Down ramp over negative limits, then bad limits
        run(0, 0, 16'h0004, -16'sd300, -16'sd50);
        fin;
        run(1, 0, 16'h0005, 16'sh0010, 16'sh0010);
        fin;
        // Preset steps both directions, clamp on the up ramp
        run(1, 1, 16'h001e, 16'sd0, 16'sd100);
        fin;
        run(0, 1, 16'h0019, -16'sd90, 16'sd10);
        fin;
        // Random limits, modes and presets
        repeat (4) begin
            r = $random(seed);
            a = 16'(r[9:0]) - 16'sd500;
            b = a + 16'(r[20:10]) + 16'sd1;
            p = r[26] ? 16'(50 + 8 * r[31:28]) : 16'(1 + r[30:28]);
            run(r[27], r[26], p, a, b);
            fin;
        end
        chk(q.size() == 0, "missing result");
        give_verdict;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict;
    end
endmodule // analog_output_ramp_generator_test
